// ==== logic/flash_status_pkg.sv ====
// How it works
// - protect bit with low pin locks registers
// - locked registers refuse every register write
// - pin gates only the status registers
// - four-wire or quad mode forces pin high
// - every live bit except latch and busy also takes volatile writes, stored copy does not
// - granularity picks sectors or blocks
// - origin bit picks top or bottom anchor
// - block bits choose the protected area
// - writes and array ops need the latch
// - enable commands set latch, disable clears
// - success clears latch, failure keeps it
// - resets load latch default, writes skip it
// - busy device takes only the short list
// - suspend only while array op runs
// - errors hold busy until clear status
// - failed or protected erase sets erase error
// - chip erase hitting protection sets error
// - failed or protected program sets error
// - errors cleared only by clear status, soft reset or hardware reset
// - erase suspend flag mirrors suspend mode
// - program suspend flag mirrors suspend mode
// - second byte reserved bits read zero
// - soft reset copies stored image into live, hardware reset loads STORED_RST into both
package flash_status_pkg;
   // ---------------------------------------------
   // field positions
   // ---------------------------------------------
   localparam int BIT_BUSY = 0;
   localparam int BIT_WEL = 1;
   localparam int BIT_ERASE_ERR = 6;
   localparam int BIT_PROG_ERR = 5;
   localparam int BIT_ERASE_SUS = 1;
   localparam int BIT_PROG_SUS = 0;
   // ---------------------------------------------
   // reset values
   // ---------------------------------------------
   localparam logic [7:0] STORED_RST = 8'h00;
   localparam logic [7:0] STATUS_TWO_RST = 8'h00;
   localparam logic WRITE_LATCH_DEFAULT = 1'b0;
   localparam logic [3:0] PINS_IDLE = 4'h5;
   // ---------------------------------------------
   // opcodes
   // ---------------------------------------------
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_VOL_WRITE_ENABLE = 8'h50;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_REG_WRITE = 8'h01;
   localparam logic [7:0] OP_WRITE_ANY = 8'h71;
   localparam logic [7:0] OP_CLEAR_STATUS = 8'h30;
   localparam logic [7:0] OP_READ_ONE = 8'h05;
   localparam logic [7:0] OP_READ_TWO = 8'h07;
   localparam logic [7:0] OP_READ_ANY = 8'h65;
   localparam logic [7:0] OP_SUSPEND = 8'h75;
   localparam logic [7:0] OP_RESUME = 8'h7a;
   localparam logic [7:0] OP_RESET_ARM = 8'h66;
   localparam logic [7:0] OP_RESET = 8'h99;
   localparam logic [7:0] OP_PROGRAM = 8'h02;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
   localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
   localparam logic [7:0] OP_CHIP_ERASE = 8'h60;
   localparam logic [7:0] OP_CHIP_ERASE_ALT = 8'hc7;
   // ---------------------------------------------
   // any-register addresses
   // ---------------------------------------------
   localparam logic [23:0] ADDR_STORED = 24'h000000;
   localparam logic [23:0] ADDR_LIVE_ONE = 24'h800000;
   localparam logic [23:0] ADDR_LIVE_TWO = 24'h800001;
   // ---------------------------------------------
   // types
   // ---------------------------------------------
   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic si;
      logic wp_n;
   } pins_t;
   typedef struct packed {
      logic start;
      logic erase;
      logic chip;
      logic suspend;
      logic resume;
   } array_req_t;
   typedef struct packed {
      logic done;
      logic fail;
   } array_rsp_t;
   typedef enum logic [2:0] {st_cmd, st_addr, st_data, st_out, st_ignore} frame_state_t;
endpackage

// ==== logic/pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync (
   input wire logic clk_sys,
   input wire logic arst_n,
   input flash_status_pkg::pins_t raw,
   output flash_status_pkg::pins_t synced
);
   import flash_status_pkg::*;
   pins_t meta_reg;
   pins_t sync_reg;
   // first stage feeds only the second
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         meta_reg <= pins_t'(PINS_IDLE);
         sync_reg <= pins_t'(PINS_IDLE);
      end else begin
         meta_reg <= raw;
         sync_reg <= meta_reg;
      end
   end
   assign synced = sync_reg;
endmodule

// ==== logic/flash_status_regs.sv ====
`timescale 1ns/1ps
module flash_status_regs (
   input wire logic clk_sys,
   input wire logic arst_n,
   input flash_status_pkg::pins_t pins,
   input wire logic four_wire_command_mode,
   input wire logic four_wire_data_mode,
   input flash_status_pkg::array_rsp_t array_rsp,
   output flash_status_pkg::array_req_t array_req,
   output logic so_out,
   output logic so_oe,
   output logic register_protected,
   output logic [7:0] status_one_live,
   output logic [7:0] status_two_live,
   output logic [7:0] status_one_stored
);
   import flash_status_pkg::*;

   // ---------------------------------------------
   // pin capture and edges
   // ---------------------------------------------
   pins_t s;
   logic sclk_d, cs_d;
   pin_sync u_sync (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .raw(pins),
      .synced(s)
   );
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sclk_d <= 1'b0;
         cs_d <= 1'b1;
      end else begin
         sclk_d <= s.sclk;
         cs_d <= s.cs_n;
      end
   end
   logic rise, fall, cs_act, cs_end;
   assign cs_act = !s.cs_n;
   assign rise = s.sclk && !sclk_d && cs_act;
   assign fall = !s.sclk && sclk_d && cs_act;
   assign cs_end = s.cs_n && !cs_d;

   // ---------------------------------------------
   // receive shifter
   // ---------------------------------------------
   logic [6:0] shift_reg;
   logic [2:0] bit_cnt;
   logic [7:0] byte_in;
   logic byte_ev;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         shift_reg <= 7'h00;
         bit_cnt <= 3'h0;
      end else if (!cs_act) begin
         bit_cnt <= 3'h0;
      end else if (rise) begin
         shift_reg <= {shift_reg[5:0], s.si};
         bit_cnt <= bit_cnt + 3'h1;
      end
   end
   assign byte_in = {shift_reg, s.si};
   assign byte_ev = rise && (bit_cnt == 3'h7);

   // ---------------------------------------------
   // status state
   // ---------------------------------------------
   logic [7:0] stored_reg;
   logic [5:0] live_reg;
   logic wel_reg, busy_reg, nv_en_reg, arm_reg;
   logic op_run_reg, op_erase_reg, erase_err_reg, prog_err_reg;
   logic erase_sus_reg, prog_sus_reg;
   frame_state_t state;
   logic [7:0] cmd_reg, data_reg;
   logic [23:0] addr_reg;
   logic [1:0] addr_cnt;
   logic wr_pend;

   // live byte: protect, granularity, origin, three block bits, then latch and busy
   assign status_one_live = {live_reg, wel_reg, busy_reg};
   assign status_two_live = {1'b0, erase_err_reg, prog_err_reg, 3'b000,
                             erase_sus_reg, prog_sus_reg};
   assign status_one_stored = stored_reg;

   // pin doubles as data line 2 in wide modes, so protection lapses there
   logic wp_level, hw_prot;
   assign wp_level = s.wp_n || four_wire_command_mode || four_wire_data_mode;
   assign hw_prot = live_reg[5] && !wp_level;
   assign register_protected = hw_prot;

   // ---------------------------------------------
   // command decode
   // ---------------------------------------------
   function automatic logic busy_ok(input logic [7:0] op);
      busy_ok = (op == OP_READ_ONE) || (op == OP_READ_TWO) || (op == OP_READ_ANY) ||
                (op == OP_SUSPEND) || (op == OP_CLEAR_STATUS) ||
                (op == OP_RESET_ARM) || (op == OP_RESET);
   endfunction
   function automatic logic is_array(input logic [7:0] op);
      is_array = (op == OP_PROGRAM) || (op == OP_SECTOR_ERASE) ||
                 (op == OP_BLOCK_ERASE) || (op == OP_CHIP_ERASE) ||
                 (op == OP_CHIP_ERASE_ALT);
   endfunction
   function automatic logic [7:0] reg_at(input logic [23:0] a);
      if (a == ADDR_STORED) reg_at = stored_reg;
      else if (a == ADDR_LIVE_ONE) reg_at = status_one_live;
      else if (a == ADDR_LIVE_TWO) reg_at = status_two_live;
      else reg_at = 8'h00;
   endfunction

   logic cmd_ev, accept;
   logic do_write_enable_cmd, do_volatile_write_enable_cmd, do_write_disable_cmd, do_clear_status_cmd, do_start, do_susp, do_resume, soft_rst;
   logic any_err, fail_done, ok_done, commit, commit_nv, commit_v;
   assign cmd_ev = byte_ev && (state == st_cmd);
   assign accept = cmd_ev && (!busy_reg || busy_ok(byte_in));
   assign do_write_enable_cmd = accept && (byte_in == OP_WRITE_ENABLE);
   assign do_volatile_write_enable_cmd = accept && (byte_in == OP_VOL_WRITE_ENABLE);
   assign do_write_disable_cmd = accept && (byte_in == OP_WRITE_DISABLE);
   assign do_clear_status_cmd = accept && (byte_in == OP_CLEAR_STATUS);
   assign do_start = accept && is_array(byte_in) && wel_reg;
   assign any_err = erase_err_reg || prog_err_reg;
   assign do_susp = accept && (byte_in == OP_SUSPEND) && busy_reg &&
                    op_run_reg && !any_err;
   assign do_resume = accept && (byte_in == OP_RESUME) && (erase_sus_reg || prog_sus_reg);
   assign soft_rst = accept && (byte_in == OP_RESET) && arm_reg;
   assign fail_done = array_rsp.done && array_rsp.fail && op_run_reg;
   assign ok_done = array_rsp.done && !array_rsp.fail && op_run_reg;
   // a refused write leaves the latch set; only the protected set looks at the pin
   assign commit = cs_end && wr_pend && wel_reg && !hw_prot;
   assign commit_nv = commit && ((cmd_reg == OP_REG_WRITE) ? nv_en_reg :
                                 (addr_reg == ADDR_STORED));
   assign commit_v = commit && ((cmd_reg == OP_REG_WRITE) ? !nv_en_reg :
                                (addr_reg == ADDR_LIVE_ONE));

   // ---------------------------------------------
   // frame sequencer
   // ---------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state <= st_cmd;
         cmd_reg <= 8'h00;
         addr_reg <= 24'h000000;
         addr_cnt <= 2'h0;
         data_reg <= 8'h00;
         wr_pend <= 1'b0;
      end else if (!cs_act) begin
         state <= st_cmd;
         wr_pend <= 1'b0;
      end else if (byte_ev) begin
         unique case (state)
            st_cmd: begin
               cmd_reg <= byte_in;
               addr_cnt <= 2'h0;
               if (!accept) state <= st_ignore;
               else if (byte_in == OP_READ_ONE) begin
                  addr_reg <= ADDR_LIVE_ONE;
                  state <= st_out;
               end else if (byte_in == OP_READ_TWO) begin
                  addr_reg <= ADDR_LIVE_TWO;
                  state <= st_out;
               end else if ((byte_in == OP_READ_ANY) || (byte_in == OP_WRITE_ANY))
                  state <= st_addr;
               else if (byte_in == OP_REG_WRITE) state <= st_data;
               else state <= st_ignore;
            end
            st_addr: begin
               addr_reg <= {addr_reg[15:0], byte_in};
               addr_cnt <= addr_cnt + 2'h1;
               if (addr_cnt == 2'h2) state <= (cmd_reg == OP_READ_ANY) ? st_out : st_data;
            end
            st_data: begin
               data_reg <= byte_in;
               wr_pend <= 1'b1;
               state <= st_ignore;
            end
            st_out, st_ignore: state <= state;
         endcase
      end
   end

   // ---------------------------------------------
   // serial output
   // ---------------------------------------------
   logic [2:0] out_idx;
   logic so_reg, oe_reg;
   logic [7:0] out_byte;
   assign out_byte = reg_at(addr_reg);
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         out_idx <= 3'h7;
         so_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else if (state != st_out) begin
         out_idx <= 3'h7;
         oe_reg <= 1'b0;
      end else if (fall) begin
         // live value each pass so polling sees busy drop
         so_reg <= out_byte[out_idx];
         out_idx <= out_idx - 3'h1;
         oe_reg <= 1'b1;
      end
   end
   assign so_out = so_reg;
   assign so_oe = oe_reg && cs_act;

   // ---------------------------------------------
   // register image and write latch
   // ---------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         stored_reg <= STORED_RST;
         live_reg <= STORED_RST[7:2];
         wel_reg <= WRITE_LATCH_DEFAULT;
         nv_en_reg <= 1'b0;
         arm_reg <= 1'b0;
      end else if (soft_rst) begin
         live_reg <= stored_reg[7:2];
         wel_reg <= WRITE_LATCH_DEFAULT;
         nv_en_reg <= 1'b0;
         arm_reg <= 1'b0;
      end else begin
         if (cmd_ev) arm_reg <= accept && (byte_in == OP_RESET_ARM);
         if (commit_nv) begin
            stored_reg[7:2] <= data_reg[7:2];
            live_reg <= data_reg[7:2];
         end else if (commit_v) begin
            live_reg <= data_reg[7:2];
         end
         if (do_write_enable_cmd || do_volatile_write_enable_cmd) begin
            wel_reg <= 1'b1;
            nv_en_reg <= do_write_enable_cmd;
         end else if (do_write_disable_cmd || do_clear_status_cmd || commit_nv || commit_v || ok_done) begin
            wel_reg <= 1'b0;
         end
      end
   end

   // ---------------------------------------------
   // array operation, busy and suspend
   // ---------------------------------------------
   array_req_t req_reg;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         busy_reg <= 1'b0;
         op_run_reg <= 1'b0;
         op_erase_reg <= 1'b0;
         erase_sus_reg <= 1'b0;
         prog_sus_reg <= 1'b0;
         req_reg <= '0;
      end else if (soft_rst) begin
         busy_reg <= 1'b0;
         op_run_reg <= 1'b0;
         erase_sus_reg <= 1'b0;
         prog_sus_reg <= 1'b0;
         req_reg <= '0;
      end else begin
         req_reg.start <= do_start;
         req_reg.erase <= do_start && (byte_in != OP_PROGRAM);
         req_reg.chip <= do_start && ((byte_in == OP_CHIP_ERASE) ||
                                      (byte_in == OP_CHIP_ERASE_ALT));
         req_reg.suspend <= do_susp;
         req_reg.resume <= do_resume;
         if (do_start) begin
            busy_reg <= 1'b1;
            op_run_reg <= 1'b1;
            op_erase_reg <= (byte_in != OP_PROGRAM);
         end else if (do_susp) begin
            busy_reg <= 1'b0;
            erase_sus_reg <= op_erase_reg;
            prog_sus_reg <= !op_erase_reg;
         end else if (do_resume) begin
            busy_reg <= 1'b1;
            erase_sus_reg <= 1'b0;
            prog_sus_reg <= 1'b0;
         end else if (ok_done) begin
            busy_reg <= 1'b0;
            op_run_reg <= 1'b0;
         end else if (fail_done) begin
            op_run_reg <= 1'b0; // busy stays up
         end else if (do_clear_status_cmd && any_err) begin
            busy_reg <= 1'b0;
         end
      end
   end
   assign array_req = req_reg;

   // ---------------------------------------------
   // error flags
   // ---------------------------------------------
   // a failure in the clearing cycle survives the clear
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         erase_err_reg <= STATUS_TWO_RST[BIT_ERASE_ERR];
         prog_err_reg <= STATUS_TWO_RST[BIT_PROG_ERR];
      end else if (soft_rst) begin
         erase_err_reg <= 1'b0;
         prog_err_reg <= 1'b0;
      end else begin
         // engine reports protected or locked targets, chip erase too, as a failure
         erase_err_reg <= (erase_err_reg && !do_clear_status_cmd) ||
                          (fail_done && op_erase_reg);
         prog_err_reg <= (prog_err_reg && !do_clear_status_cmd) ||
                         (fail_done && !op_erase_reg);
      end
   end

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   sequence s_arm_then_reset;
      (accept && (byte_in == OP_RESET_ARM)) ##1 (!cmd_ev)[*1] ##[0:200]
      (cmd_ev && (byte_in == OP_RESET) && arm_reg);
   endsequence
   sequence s_fail_seen;
      fail_done ##1 busy_reg;
   endsequence

   a_locked_stored: assert property (hw_prot |=> $stable(stored_reg))
      else $error("stored status changed while locked");
   a_wide_unlocks: assert property (four_wire_data_mode |-> !hw_prot)
      else $error("protection active in wide mode");
   a_write_needs_latch: assert property ($changed(live_reg) && !$past(soft_rst)
      |-> $past(wel_reg))
      else $error("live status written without latch");
   a_enable_sets: assert property (do_write_enable_cmd |=> wel_reg
      ##1 (wel_reg || !$past(wel_reg)))
      else $error("write enable did not set latch");
   a_success_clears: assert property (ok_done && !do_write_enable_cmd |=> !wel_reg && !busy_reg)
      else $error("success left latch or busy");
   a_busy_refuses: assert property (cmd_ev && busy_reg && !busy_ok(byte_in)
      |=> state == st_ignore && $stable(wel_reg))
      else $error("busy device took a command");
   a_suspend_running: assert property (array_req.suspend |-> $past(op_run_reg, 1))
      else $error("suspend without running operation");
   a_error_busy: assert property (s_fail_seen |-> (busy_reg throughout
      (any_err)[*3]) or do_clear_status_cmd or $past(do_clear_status_cmd))
      else $error("error without busy");
   a_erase_error: assert property (fail_done && op_erase_reg |=> erase_err_reg ##1
      (erase_err_reg || $past(do_clear_status_cmd) || $past(soft_rst)))
      else $error("erase failure not flagged");
   a_clear_status: assert property (do_clear_status_cmd && !fail_done |=>
      !erase_err_reg && !prog_err_reg)
      else $error("clear status left an error");
   a_soft_reset: assert property (s_arm_then_reset |=> wel_reg == WRITE_LATCH_DEFAULT &&
      live_reg == stored_reg[7:2] && !busy_reg)
      else $error("soft reset did not reload");
   a_reserved_zero: assert property (status_two_live[7] == 1'b0 &&
      status_two_live[4:2] == 3'b000 ##1 status_two_live[7] == 1'b0)
      else $error("reserved status bit set");
endmodule

// ==== testbench/spi_host_model.sv ====
`timescale 1ns/1ps
module spi_host_model (
   input wire logic clk_sys,
   input wire logic so_out,
   output logic sclk,
   output logic cs_n,
   output logic si,
   output logic rd_valid,
   output logic [7:0] rd_byte
);
   logic idle = 1'b1;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
      rd_valid = 1'b0;
      rd_byte = 8'h00;
   end
   // ---------------------------------------------
   // released data line
   // ---------------------------------------------
   // toggles so a stale bit never passes for data
   always @(posedge clk_sys) begin
      if (idle) begin
         si <= ~si;
      end
   end
   // ---------------------------------------------
   // mode 0 frames, msb first
   // ---------------------------------------------
   // sclk: 4 clk low, 4 clk high (160 ns), data read at the fall edge
   task automatic bit_cycle(input logic b, output logic r);
      sclk <= 1'b0;
      si <= b;
      repeat (4) @(posedge clk_sys);
      sclk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      r = so_out;
   endtask
   task automatic frame(input logic [7:0] op, input logic [7:0] dat, input bit wr, input int nrd);
      logic r;
      logic [7:0] sh;
      idle = 1'b0;
      @(posedge clk_sys);
      cs_n <= 1'b0;
      for (int i = 7; i >= 0; i--) bit_cycle(op[i], r);
      if (wr) begin
         for (int i = 7; i >= 0; i--) bit_cycle(dat[i], r);
      end
      for (int n = 0; n < nrd; n++) begin
         for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b0, r);
            sh[i] = r;
         end
         rd_byte <= sh;
         rd_valid <= 1'b1;
         @(posedge clk_sys);
         rd_valid <= 1'b0;
      end
      @(posedge clk_sys);
      sclk <= 1'b0;
      repeat (4) @(posedge clk_sys);
      cs_n <= 1'b1;
      idle = 1'b1;
      repeat (12) @(posedge clk_sys);
   endtask
endmodule

// ==== testbench/tb_flash_status_regs.sv ====
`timescale 1ns/1ps
module tb_flash_status_regs;
   import flash_status_pkg::*;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic wp_n = 1'b1;
   logic cmd_mode = 1'b0;
   logic data_mode = 1'b0;
   array_rsp_t array_rsp = '0;
   array_req_t array_req;
   array_req_t last_req;
   pins_t pins;
   logic sclk, cs_n, si, so_out, so_oe, reg_prot, rd_valid;
   logic [7:0] rd_byte, s1, s2, st, d, op;
   logic [7:0] exp_q[$];
   int error_cnt = 0;
   int total_checks = 0;
   int n_start = 0;
   int n_sus = 0;
   always #10 clk_sys = ~clk_sys;
   assign pins = '{sclk: sclk, cs_n: cs_n, si: si, wp_n: wp_n};
   flash_status_regs u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .pins(pins),
      .four_wire_command_mode(cmd_mode), .four_wire_data_mode(data_mode),
      .array_rsp(array_rsp), .array_req(array_req), .so_out(so_out), .so_oe(so_oe),
      .register_protected(reg_prot), .status_one_live(s1), .status_two_live(s2),
      .status_one_stored(st));
   spi_host_model u_host (.clk_sys(clk_sys), .so_out(so_out), .sclk(sclk), .cs_n(cs_n),
      .si(si), .rd_valid(rd_valid), .rd_byte(rd_byte));
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic cmd(input logic [7:0] c);
      u_host.frame(c, 8'h00, 1'b0, 0);
   endtask
   task automatic wr(input logic [7:0] en, input logic [7:0] v);
      cmd(en);
      u_host.frame(OP_REG_WRITE, v, 1'b1, 0);
   endtask
   // two bytes read back to back: the byte must repeat while selected
   task automatic rd(input logic [7:0] c, input logic [7:0] e);
      exp_q.push_back(e);
      exp_q.push_back(e);
      u_host.frame(c, 8'h00, 1'b0, 2);
   endtask
   task automatic finish_op(input logic f);
      @(posedge clk_sys);
      array_rsp <= '{done: 1'b1, fail: f};
      @(posedge clk_sys);
      array_rsp <= '0;
      repeat (3) @(posedge clk_sys);
   endtask
   // ---------------------------------------------
   // watchers
   // ---------------------------------------------
   always @(posedge clk_sys) begin
      if (array_req.start === 1'b1) begin
         n_start <= n_start + 1;
         last_req <= array_req;
      end
      if (array_req.suspend === 1'b1) begin
         n_sus <= n_sus + 1;
      end
      if (rd_valid === 1'b1) begin
         chk({7'h0, so_oe}, 8'h01, "output enable while reading");
         if (exp_q.size() == 0) begin
            chk(rd_byte, 8'hxx, "read with nothing expected");
         end else begin
            chk(rd_byte, exp_q.pop_front(), "status read");
         end
      end
   end
   initial begin
      repeat (60000) @(posedge clk_sys);
      error_cnt++;
      $display("unexpected at %0t: run timed out", $time);
      test_done();
   end
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      void'($urandom(32'h4a902d13));
      repeat (2) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk(s1, STORED_RST, "live one after reset");
      chk(s2, STATUS_TWO_RST, "live two after reset");
      $display("test reset done");
      cmd(OP_WRITE_ENABLE);
      chk(s1, 8'h02, "enable");
      cmd(OP_WRITE_DISABLE);
      chk(s1, 8'h00, "disable");
      cmd(OP_VOL_WRITE_ENABLE);
      chk(s1, 8'h02, "volatile enable");
      cmd(OP_WRITE_DISABLE);
      u_host.frame(OP_REG_WRITE, 8'h7c, 1'b1, 0);
      chk(s1, 8'h00, "write without latch");
      d = 8'($urandom()) & 8'h7c;
      wr(OP_WRITE_ENABLE, d);
      chk(st, d, "stored write");
      chk(s1 & 8'hfc, d, "live follows stored");
      cmd(OP_WRITE_DISABLE);
      rd(OP_READ_ONE, d);
      rd(OP_READ_TWO, 8'h00);
      $display("test latch and write done");
      wr(OP_WRITE_ENABLE, 8'h80);
      wp_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chk({7'h0, reg_prot}, 8'h01, "protect mode");
      wr(OP_VOL_WRITE_ENABLE, 8'h00);
      chk(s1, 8'h82, "locked write");
      for (int m = 1; m < 4; m++) begin
         {cmd_mode, data_mode} <= m[1:0];
         repeat (4) @(posedge clk_sys);
         chk({7'h0, reg_prot}, 8'h00, "wide mode unlocks");
      end
      wr(OP_WRITE_ENABLE, 8'h00);
      chk(s1 & 8'hfc, 8'h00, "unlocked write");
      {cmd_mode, data_mode} <= 2'b00;
      $display("test protect done");
      // wp still low: array work is outside the locked set
      cmd(OP_WRITE_DISABLE);
      cmd(OP_PROGRAM);
      chk(8'(n_start), 8'h00, "program without latch");
      cmd(OP_WRITE_ENABLE);
      cmd(OP_PROGRAM);
      chk(8'(n_start), 8'h01, "program start");
      cmd(OP_WRITE_DISABLE);
      chk(s1, 8'h03, "disable ignored while busy");
      rd(OP_READ_ONE, 8'h03);
      finish_op(1'b0);
      chk(s1, 8'h00, "program done");
      wp_n <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         op = (k == 0) ? OP_PROGRAM : (k == 1) ? OP_SECTOR_ERASE : OP_CHIP_ERASE;
         cmd(OP_WRITE_ENABLE);
         cmd(op);
         chk({6'h0, last_req.erase, last_req.chip}, {6'h0, k != 0, k == 2}, "op kind");
         finish_op(1'b1);
         chk(s2, (k == 0) ? 8'h20 : 8'h40, "error flag");
         chk(s1 & 8'h01, 8'h01, "busy held");
         cmd(op);
         chk(8'(n_start), 8'(2 + k), "refused after error");
         cmd(OP_CLEAR_STATUS);
         chk(s2, 8'h00, "clear status");
         chk(s1, 8'h00, "standby after clear");
      end
      $display("test errors done");
      cmd(OP_SUSPEND);
      chk(8'(n_sus), 8'h00, "suspend while idle");
      for (int k = 0; k < 2; k++) begin
         cmd(OP_WRITE_ENABLE);
         cmd((k == 0) ? OP_PROGRAM : OP_BLOCK_ERASE);
         cmd(OP_SUSPEND);
         chk(8'(n_sus), 8'(k + 1), "suspend taken");
         chk(s2, (k == 0) ? 8'h01 : 8'h02, "suspend flag");
         cmd(OP_RESUME);
         chk(s2, 8'h00, "resumed");
         finish_op(1'b0);
      end
      $display("test suspend done");
      wr(OP_WRITE_ENABLE, 8'h24);
      wr(OP_VOL_WRITE_ENABLE, 8'h58);
      cmd(OP_WRITE_ENABLE);
      cmd(OP_PROGRAM);
      cmd(OP_RESET_ARM);
      cmd(OP_RESET);
      chk(s1, 8'h24 | {6'h0, WRITE_LATCH_DEFAULT, 1'b0}, "soft reset");
      chk(8'(exp_q.size()), 8'h00, "reads drained");
      $display("test soft reset done");
      test_done();
   end
endmodule
